// ===== design/abpm_consts.vh
// Register map, field layout and encodings of the bus performance monitor
`ifndef ABPM_CONSTS_VH
`define ABPM_CONSTS_VH

// ****************************************************************
// Register word offsets (byte addresses, low bits of haddr)
// ****************************************************************
`define ABPM_ADDR_W 8
`define ABPM_OFF_CTRL 8'h04
`define ABPM_OFF_CYCLO 8'h08
`define ABPM_OFF_EV0L 8'h0C
`define ABPM_OFF_EV1L 8'h10
`define ABPM_OFF_HIGH 8'h14

// ****************************************************************
// Control register fields
// ****************************************************************
`define ABPM_CTL_MSEL1 23:20
`define ABPM_CTL_MSEL0 19:16
`define ABPM_CTL_ESEL1 14:12
`define ABPM_CTL_ESEL0 10:8
`define ABPM_CTL_EN1 2
`define ABPM_CTL_EN0 1
`define ABPM_CTL_CYCEN 0

// ****************************************************************
// Shared high register fields
// ****************************************************************
`define ABPM_HI_CLK 31:16
`define ABPM_HI_CH1 15:8
`define ABPM_HI_CH0 7:0
`define ABPM_HI_SAT 8'hFF

// ****************************************************************
// Event codes, master codes and observed bus encodings
// ****************************************************************
`define ABPM_EV_CYC 3'h0
`define ABPM_EV_NSEQ 3'h1
`define ABPM_EV_LAT 3'h2
`define ABPM_EV_LATC 3'h3
`define ABPM_EV_SINGLE 3'h4
`define ABPM_EV_FIXED 3'h5
`define ABPM_EV_INCR 3'h6
`define ABPM_EV_CYCC 3'h7
`define ABPM_MST_ALL 4'hF
`define ABPM_TR_IDLE 2'h0
`define ABPM_TR_NONSEQ 2'h2
`define ABPM_BU_SINGLE 3'h0
`define ABPM_BU_INCR 3'h1
`define ABPM_RST_WORD 32'h00000000

`endif

// ===== design/abpm_cycle_ctr.v
// Free-running bus clock-cycle counter, 32-bit low and 16-bit high part
`timescale 1ns/100ps
module abpm_cycle_ctr #(
  parameter LO_W = 32,
  parameter HI_W = 16
) (
  input wire clk,
  input wire rst_n,
  input wire count_en,
  input wire wr_low,
  input wire wr_high,
  input wire [LO_W-1:0] wdata_low,
  input wire [HI_W-1:0] wdata_high,
  output reg [LO_W-1:0] count_low_r,
  output reg [HI_W-1:0] count_high_r
);

  wire lo_full;

  assign lo_full = &count_low_r;

  // Software writes win over counting so a preset is never lost
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_r <= {LO_W{1'b0}};
      count_high_r <= {HI_W{1'b0}};
    end else begin
      if (wr_low) begin
        count_low_r <= wdata_low;
      end else if (count_en) begin
        count_low_r <= count_low_r + 1'b1;
      end
      if (wr_high) begin
        count_high_r <= wdata_high;
      end else if (count_en && lo_full && !wr_low) begin
        count_high_r <= count_high_r + 1'b1; // Upper part wraps
      end
    end
  end

endmodule // abpm_cycle_ctr

// ===== design/abpm_evt_ctr.v
// Event counter: 32-bit low word plus saturating high byte
`timescale 1ns/100ps
module abpm_evt_ctr #(
  parameter LO_W = 32,
  parameter HI_W = 8
) (
  input wire clk,
  input wire rst_n,
  input wire [LO_W-1:0] add_val,
  input wire bump_high,
  input wire wr_low,
  input wire wr_high,
  input wire [LO_W-1:0] wdata_low,
  input wire [HI_W-1:0] wdata_high,
  output reg [LO_W-1:0] count_low_r,
  output reg [HI_W-1:0] count_high_r
);

  wire [LO_W:0] sum;
  wire carry;
  wire hi_full;

  assign sum = {1'b0, count_low_r} + {1'b0, add_val};
  assign carry = sum[LO_W];
  assign hi_full = &count_high_r;

  // Low wraps into high; high sticks at all ones until rewritten
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_low_r <= {LO_W{1'b0}};
      count_high_r <= {HI_W{1'b0}};
    end else begin
      if (wr_low) begin
        count_low_r <= wdata_low;
      end else begin
        count_low_r <= sum[LO_W-1:0];
      end
      if (wr_high) begin
        count_high_r <= wdata_high;
      end else if ((bump_high || (carry && !wr_low)) && !hi_full) begin
        count_high_r <= count_high_r + 1'b1;
      end
    end
  end

endmodule // abpm_evt_ctr

// ===== design/abpm_top.v
// Bus performance monitor: AHB-Lite register slave and event channels
`timescale 1ns/100ps
`include "abpm_consts.vh"
module abpm_top #(
  parameter NMST = 8,
  parameter NCH = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_r,
  output reg hreadyout_r,
  output reg hresp_r,
  input wire [1:0] mon_htrans,
  input wire [2:0] mon_hburst,
  input wire [3:0] mon_hmaster,
  input wire mon_hready,
  input wire [NMST-1:0] mon_busreq,
  input wire [NMST-1:0] mon_grant
);

  // ****************************************************************
  // Bus slave state
  // ****************************************************************
  reg wr_pend_r;
  reg rd_pend_r;
  reg [`ABPM_ADDR_W-1:0] addr_r;
  wire accept;
  wire [`ABPM_ADDR_W-1:0] dp_addr;
  wire wr_ctrl;
  wire wr_cyclo;
  wire wr_high;
  wire [NCH-1:0] wr_evl;
  wire hit_ctrl;
  wire hit_cyclo;
  wire hit_ev0l;
  wire hit_ev1l;
  wire hit_high;
  reg [31:0] rd_mux;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  reg [3:0] chan1_master_select_r;
  reg [3:0] chan0_master_select_r;
  reg [2:0] chan1_event_select_r;
  reg [2:0] chan0_event_select_r;
  reg chan1_enable_r;
  reg chan0_enable_r;
  reg cycle_count_enable_r;
  wire [31:0] ctrl_word;

  // Counter views
  wire [31:0] clk_lo;
  wire [15:0] clk_hi;
  wire [31:0] ev_lo [0:NCH-1];
  wire [7:0] ev_hi [0:NCH-1];

  // Address phase taken only for active transfers while the bus is ready
  assign accept = hsel && hready && htrans[1];
  assign dp_addr = addr_r;

  // ****************************************************************
  // Register address decode
  // ****************************************************************
  // One decode of the held data-phase word serves writes and reads, so
  // the two can never disagree about which register an offset names
  assign hit_ctrl = (dp_addr == `ABPM_OFF_CTRL);
  assign hit_cyclo = (dp_addr == `ABPM_OFF_CYCLO);
  assign hit_ev0l = (dp_addr == `ABPM_OFF_EV0L);
  assign hit_ev1l = (dp_addr == `ABPM_OFF_EV1L);
  assign hit_high = (dp_addr == `ABPM_OFF_HIGH);

  // Writes land in the data phase, one cycle after the address phase;
  // hsize is not decoded, so a narrow write would replace the whole word
  assign wr_ctrl = wr_pend_r && hit_ctrl;
  assign wr_cyclo = wr_pend_r && hit_cyclo;
  assign wr_high = wr_pend_r && hit_high;
  assign wr_evl[0] = wr_pend_r && hit_ev0l;
  assign wr_evl[1] = wr_pend_r && hit_ev1l;

  // ****************************************************************
  // AHB-Lite slave handshake
  // ****************************************************************
  // Reads take one wait state so a read that follows a write sees
  // the written value rather than the stale one.
  // Writes need no wait: the data-phase word is taken at the edge that
  // ends it, and the register holds it from then on.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= {`ABPM_ADDR_W{1'b0}};
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= `ABPM_RST_WORD;
    end else begin
      hresp_r <= 1'b0; // Always OKAY
      if (rd_pend_r) begin
        rd_pend_r <= 1'b0;
        hrdata_r <= rd_mux;
        hreadyout_r <= 1'b1;
      end else if (accept) begin
        addr_r <= {haddr[`ABPM_ADDR_W-1:2], 2'b00};
        wr_pend_r <= hwrite;
        rd_pend_r <= !hwrite;
        hreadyout_r <= hwrite;
      end else begin
        wr_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Reserved bits have no storage, so writes to them vanish
  // Enables reset to zero, so nothing counts before software sets it up
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan1_master_select_r <= 4'h0;
      chan0_master_select_r <= 4'h0;
      chan1_event_select_r <= 3'h0;
      chan0_event_select_r <= 3'h0;
      chan1_enable_r <= 1'b0;
      chan0_enable_r <= 1'b0;
      cycle_count_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      chan1_master_select_r <= hwdata[`ABPM_CTL_MSEL1];
      chan0_master_select_r <= hwdata[`ABPM_CTL_MSEL0];
      chan1_event_select_r <= hwdata[`ABPM_CTL_ESEL1];
      chan0_event_select_r <= hwdata[`ABPM_CTL_ESEL0];
      chan1_enable_r <= hwdata[`ABPM_CTL_EN1];
      chan0_enable_r <= hwdata[`ABPM_CTL_EN0];
      cycle_count_enable_r <= hwdata[`ABPM_CTL_CYCEN];
    end
  end

  // Reserved positions fill with zero on read
  assign ctrl_word = {8'h00, chan1_master_select_r, chan0_master_select_r, 1'b0,
                      chan1_event_select_r, 1'b0, chan0_event_select_r, 5'h00,
                      chan1_enable_r, chan0_enable_r, cycle_count_enable_r};

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Unmapped words, including offset zero, read as zero
  always @* begin
    if (hit_ctrl) begin
      rd_mux = ctrl_word;
    end else if (hit_cyclo) begin
      rd_mux = clk_lo;
    end else if (hit_ev0l) begin
      rd_mux = ev_lo[0];
    end else if (hit_ev1l) begin
      rd_mux = ev_lo[1];
    end else if (hit_high) begin
      rd_mux = {clk_hi, ev_hi[1], ev_hi[0]};
    end else begin
      rd_mux = `ABPM_RST_WORD;
    end
  end

  // ****************************************************************
  // Clock-cycle counter
  // ****************************************************************
  // The full count rolls over silently; software timing long spans must
  // read the high field before and after the low word
  abpm_cycle_ctr #(
    .LO_W(32),
    .HI_W(16)
  ) u_cyc (
    .clk(hclk),
    .rst_n(hresetn),
    .count_en(cycle_count_enable_r),
    .wr_low(wr_cyclo),
    .wr_high(wr_high),
    .wdata_low(hwdata),
    .wdata_high(hwdata[`ABPM_HI_CLK]),
    .count_low_r(clk_lo),
    .count_high_r(clk_hi)
  );

  // ****************************************************************
  // Event channels
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      wire [3:0] msel;
      wire [2:0] esel;
      wire en;
      wire match;
      wire act;
      wire start;
      wire waiting;
      wire txn_end;
      wire [7:0] hi_wdata;
      reg [31:0] lat_r;
      reg [31:0] txn_cyc_r;
      reg in_txn_r;
      reg [31:0] add_val;
      reg bump;

      // Each channel takes its own fields out of the shared control word
      assign msel = (gi == 0) ? chan0_master_select_r : chan1_master_select_r;
      assign esel = (gi == 0) ? chan0_event_select_r : chan1_event_select_r;
      assign en = (gi == 0) ? chan0_enable_r : chan1_enable_r;
      assign hi_wdata = (gi == 0) ? hwdata[`ABPM_HI_CH0] : hwdata[`ABPM_HI_CH1];

      // Code 15 watches every master; any other code, 8 to 14 included, matches an equal mon_hmaster
      assign match = (msel == `ABPM_MST_ALL) || (mon_hmaster == msel);
      assign act = en && match && (mon_htrans != `ABPM_TR_IDLE);
      assign start = en && match && mon_hready && (mon_htrans == `ABPM_TR_NONSEQ);
      // Request lines exist only for real masters; all-masters gives none,
      // so the latency codes cannot be trusted with every master selected
      assign waiting = en && !msel[3] && mon_busreq[msel[2:0]] && !mon_grant[msel[2:0]];
      assign txn_end = in_txn_r && (start || !act);

      // Per-transaction trackers: waiting cycles and active cycles
      // Disabling clears them; the first disabled cycle still ends an open transaction, so ABPM_EV_CYCC can score a half-seen one
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          lat_r <= 32'h00000000;
          txn_cyc_r <= 32'h00000000;
          in_txn_r <= 1'b0;
        end else if (!en) begin
          lat_r <= 32'h00000000;
          txn_cyc_r <= 32'h00000000;
          in_txn_r <= 1'b0;
        end else begin
          lat_r <= start ? 32'h00000000 : lat_r + {31'h00000000, waiting};
          if (start) begin
            txn_cyc_r <= 32'h00000001;
            in_txn_r <= 1'b1;
          end else if (act) begin
            txn_cyc_r <= txn_cyc_r + 32'h00000001;
          end else begin
            in_txn_r <= 1'b0;
          end
        end
      end

      // Event decode: amount to add to the low word, or a high bump
      // Only one arm is live per channel, so no event counts twice a cycle
      always @* begin
        add_val = 32'h00000000;
        bump = 1'b0;
        case (esel)
          `ABPM_EV_CYC: begin
            add_val = {31'h00000000, act};
          end
          `ABPM_EV_NSEQ: begin
            add_val = {31'h00000000, start};
          end
          `ABPM_EV_LAT: begin
            add_val = start ? lat_r : 32'h00000000;
          end
          `ABPM_EV_LATC: begin
            bump = start && (lat_r > ev_lo[gi]);
          end
          `ABPM_EV_SINGLE: begin
            add_val = {31'h00000000, start && (mon_hburst == `ABPM_BU_SINGLE)};
          end
          `ABPM_EV_FIXED: begin
            add_val = {31'h00000000, start && (mon_hburst != `ABPM_BU_SINGLE) &&
                       (mon_hburst != `ABPM_BU_INCR)};
          end
          `ABPM_EV_INCR: begin
            add_val = {31'h00000000, start && (mon_hburst == `ABPM_BU_INCR)};
          end
          default: begin
            bump = txn_end && (txn_cyc_r > ev_lo[gi]);
          end
        endcase
      end

      // Counter pair for this channel; the low word doubles as threshold
      // A software write to either half wins over an event for that half in that cycle
      abpm_evt_ctr #(
        .LO_W(32),
        .HI_W(8)
      ) u_evt (
        .clk(hclk),
        .rst_n(hresetn),
        .add_val(add_val),
        .bump_high(bump),
        .wr_low(wr_evl[gi]),
        .wr_high(wr_high),
        .wdata_low(hwdata),
        .wdata_high(hi_wdata),
        .count_low_r(ev_lo[gi]),
        .count_high_r(ev_hi[gi])
      );
    end
  endgenerate

endmodule // abpm_top

// ===== verif/abpm_top_sva.sv
// Bus-side assertions for the bus performance monitor
`timescale 1ns/100ps
module abpm_top_sva (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata_r,
  input wire hreadyout_r,
  input wire hresp_r
);
  // ********
  // Shadow of software writes
  // ********
  reg [7:0] a_r;
  reg rp_r;
  reg wp_r;
  reg cl_ok_r;
  reg [31:0] ctl_r;
  reg [31:0] cl_r;
  wire take = hsel && hready && htrans[1];
  wire ans = rp_r && hreadyout_r;
  wire wdp = wp_r && hready;
  // The cycle count is trusted only while it is stopped, since it moves every edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_r <= 8'h00;
      rp_r <= 1'h0;
      wp_r <= 1'h0;
      ctl_r <= 32'h00000000;
      cl_r <= 32'h00000000;
      cl_ok_r <= 1'h1;
    end else begin
      if (take) begin
        a_r <= haddr[7:0];
      end
      rp_r <= (take && !hwrite) || (rp_r && !hreadyout_r);
      wp_r <= (take && hwrite) || (wp_r && !hready);
      if (wdp && a_r == 8'h04) begin
        ctl_r <= hwdata & 32'h00FF7707;
        cl_ok_r <= cl_ok_r && !hwdata[0];
      end
      if (wdp && a_r == 8'h08) begin
        cl_r <= hwdata;
        cl_ok_r <= !ctl_r[0];
      end
    end
  end
  // ********
  // Assertions
  // ********
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (hresp_r == 1'h0)
    else $error("slave response not OKAY");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout_r)
    else $error("write was stalled");
  rdata_hold_a: assert property (hreadyout_r && $past(hreadyout_r) |-> $stable(hrdata_r))
    else $error("read data moved between answers");
  ctrl_fields_a: assert property (ans && a_r == 8'h04 |-> hrdata_r == ctl_r)
    else $error("control fields differ from last write");
  ctrl_resv_a: assert property (ans && a_r == 8'h04 |-> (hrdata_r & 32'hFF0088F8) == 32'h0)
    else $error("unused control bits not zero");
  clk_hold_a: assert property (ans && a_r == 8'h08 && cl_ok_r |-> hrdata_r == cl_r)
    else $error("stopped cycle count moved");
  unmapped_zero_a: assert property (ans && (a_r[7:2] == 6'h0 || a_r > 8'h14) |-> hrdata_r == 32'h0)
    else $error("empty offset read not zero");
  ctrl_rd_c: cover property (ans && a_r == 8'h04);
  high_rd_c: cover property (ans && a_r == 8'h14);
  clk_wr_c: cover property (take && hwrite && haddr[7:0] == 8'h08);
endmodule // abpm_top_sva

bind abpm_top abpm_top_sva chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata_r,
  .hreadyout_r, .hresp_r);

// ===== verif/abpm_bus_model.sv
// Behavioural model of the observed bus masters and arbiter
`timescale 1ns/100ps
module abpm_bus_model (
  input wire hclk,
  output logic [1:0] mon_htrans,
  output logic [2:0] mon_hburst,
  output logic [3:0] mon_hmaster,
  output logic mon_hready,
  output logic [7:0] mon_busreq,
  output logic [7:0] mon_grant
);
  // Quiet bus at start
  initial begin
    mon_htrans = 2'h0;
    mon_hburst = 3'h7;
    mon_hmaster = 4'hC;
    mon_hready = 1'h1;
    mon_busreq = 8'h00;
    mon_grant = 8'h00;
  end
  // Request, wait for grant, NONSEQ (stalled if asked), SEQ beats, release
  task automatic xfer(input logic [3:0] m, input logic [2:0] b, input int beats, input int stall, input int waitc);
    begin
      mon_busreq[m] <= 1'h1;
      repeat (waitc) @(posedge hclk);
      mon_grant[m] <= 1'h1;
      mon_hmaster <= m;
      mon_hburst <= b;
      mon_htrans <= 2'h2;
      mon_hready <= (stall == 0);
      repeat (stall) @(posedge hclk);
      if (stall > 0) mon_hready <= 1'h1;
      @(posedge hclk);
      repeat (beats - 1) begin
        mon_htrans <= 2'h3;
        @(posedge hclk);
      end
      // Released mon_hmaster and mon_hburst show the inverse so a stale value cannot pass for a live one
      mon_htrans <= 2'h0;
      mon_busreq[m] <= 1'h0;
      mon_grant[m] <= 1'h0;
      mon_hmaster <= ~m;
      mon_hburst <= ~b;
      @(posedge hclk);
    end
  endtask
endmodule // abpm_bus_model

// ===== verif/tb.sv
// Self-checking bench for the bus performance monitor
`timescale 1ns/100ps
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m;} abpm_note_t;
  logic hclk, hresetn, hsel, hwrite, rd_due;
  logic [31:0] haddr, hwdata, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata_r;
  wire hreadyout_r, hresp_r, hready, mon_hready;
  wire [1:0] mon_htrans;
  wire [2:0] mon_hburst;
  wire [3:0] mon_hmaster;
  wire [7:0] mon_busreq, mon_grant;
  int bad_count, checks_done;
  abpm_note_t q[$];
  abpm_note_t e;
  logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
  int ex0 [5] = '{8, 3, 1, 1, 1};
  int ex1 [5] = '{12, 4, 1, 2, 1};
  assign hready = hreadyout_r;
  abpm_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata_r,
    .hreadyout_r, .hresp_r, .mon_htrans, .mon_hburst, .mon_hmaster, .mon_hready, .mon_busreq, .mon_grant);
  abpm_bus_model bus_m (.hclk, .mon_htrans, .mon_hburst, .mon_hmaster, .mon_hready, .mon_busreq, .mon_grant);
  initial begin
    hclk = 1'h0;
    forever #5 hclk = ~hclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ********
  // Bus master and scoreboard
  // ********
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    begin
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      if (wr) hwdata <= d;
      else begin
        q.push_back('{a, d, m});
        rd_due <= 1'h1;
      end
      do @(posedge hclk); while (hready !== 1'h1);
      rd_due <= 1'h0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFFFFFFFF);
    bus(1'h0, a, d, m);
  endtask
  task automatic traffic;
    bus_m.xfer(4'h3, 3'h0, 1, 0, 0);
    bus_m.xfer(4'h3, 3'h3, 4, 0, 0);
    bus_m.xfer(4'h3, 3'h1, 2, 1, 0);
    bus_m.xfer(4'h5, 3'h2, 4, 0, 0);
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk) begin
    if (rd_due && hready === 1'h1) begin
      e = q.pop_front();
      checks_done++;
      if ((hrdata_r & e.m) !== (e.d & e.m)) begin
        bad_count++;
        $display("CHECK FAILED reg %h expected %h seen %h", e.a, e.d & e.m, hrdata_r & e.m);
      end
    end
  end
  task automatic wrap_up;
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog: about thirty times the expected run
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  // ********
  // Scenarios
  // ********
  initial begin
    {hresetn, hsel, hwrite, rd_due, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    rnd = 32'h314B83C9;
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    wr(8'h18, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0);
    repeat (4) begin
      rnd = lfsr(rnd);
      wr(8'h04, rnd);
      rd(8'h04, rnd & 32'h00FF7707);
    end
    // Two enabled edges carry the low word into the high field
    wr(8'h04, 32'h0);
    wr(8'h08, 32'hFFFFFFFE);
    wr(8'h14, 32'h0);
    rd(8'h08, 32'hFFFFFFFE);
    wr(8'h04, 32'h1);
    wr(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h14, 32'h00010000);
    // Each counting code; channel 1 watches all masters, disabled traffic must not count
    for (int k = 0; k < 5; k++) begin
      wr(8'h0C, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h04, {8'h00, 4'hF, 4'h3, 1'h0, cd[k], 1'h0, cd[k], 8'h06});
      traffic();
      wr(8'h04, 32'h0);
      traffic();
      rd(8'h0C, 32'(ex0[k]));
      rd(8'h10, 32'(ex1[k]));
    end
    // Latency codes always name one master, never all of them
    wr(8'h0C, 32'hFFFFFFFE);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h00333206);
    bus_m.xfer(4'h3, 3'h0, 1, 0, 3);
    bus_m.xfer(4'h3, 3'h0, 1, 0, 1);
    rd(8'h0C, 32'h2);
    rd(8'h14, 32'h00000101);
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h2);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0000FE00);
    wr(8'h04, 32'h00337706);
    bus_m.xfer(4'h3, 3'h3, 4, 0, 0);
    bus_m.xfer(4'h3, 3'h0, 1, 0, 0);
    bus_m.xfer(4'h3, 3'h0, 1, 0, 0);
    rd(8'h14, 32'h0000FF01);
    wrap_up();
  end
endmodule // tb
